/* File: core/pfp_pkg.sv */
// Purpose: Shared constants and state types for the parallel flash programming port
// Assumes: One 100 MHz system clock on both ends
// Notes:   Times are in ns; cycle counts are derived from the clock period
package pfp_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 10;
    // Action select codes {hi, lo}
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;
    // Command bytes
    localparam logic [7:0] CMD_NOP         = 8'h00;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
    // Memory geometry
    localparam int FLASH_AW   = 12;
    localparam int EE_AW      = 9;
    localparam int PAGE_AW    = 5;
    localparam int PAGE_NUM_W = FLASH_AW - PAGE_AW;
    localparam logic [11:0] FLASH_LAST = 12'hFFF;
    localparam logic [11:0] EE_LAST    = 12'h1FF;
    localparam logic [11:0] PAGE_LAST  = 12'h01F;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [1:0]  LOCK_RESET  = 2'h0;
    localparam logic [1:0]  LOCK_ERASED = 2'h3;
    // Timing
    localparam int PROG_SETTLE_NS  = 100;
    localparam int PROG_SETTLE_CYC = (PROG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] SETTLE_LAST = 12'(PROG_SETTLE_CYC - 1);
    localparam int LINK_STEP_NS  = 40;
    localparam int LINK_STEP_CYC = (LINK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STEP_LAST = 4'(LINK_STEP_CYC - 1);
    localparam int BUSY_GAP_NS  = 100;
    localparam int BUSY_GAP_CYC = (BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] GAP_LAST = 4'(BUSY_GAP_CYC - 1);
    // Programmer register offsets
    localparam logic [1:0] REG_LOAD   = 2'h0;
    localparam logic [1:0] REG_WRITE  = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    // Status bit positions
    localparam int STAT_READY   = 0;
    localparam int STAT_BUSY    = 1;
    localparam int STAT_REFUSED = 2;
    // Device sequencer
    typedef enum logic [5:0] {
        ST_IDLE        = 6'h01,
        ST_ERASE_FLASH = 6'h02,
        ST_ERASE_EE    = 6'h04,
        ST_ERASE_LOCK  = 6'h08,
        ST_PAGE_COPY   = 6'h10,
        ST_SETTLE      = 6'h20
    } dev_state_e;
    // Programmer sequencer
    typedef enum logic [5:0] {
        H_IDLE   = 6'h01,
        H_SETUP  = 6'h02,
        H_STROBE = 6'h04,
        H_HOLD   = 6'h08,
        H_WRLOW  = 6'h10,
        H_GAP    = 6'h20
    } host_state_e;
endpackage

/* File: core/pfp_if.sv */
// Purpose: Pin bundle between programmer and device
// Assumes: Programmer only writes; the data bus is one-way here
// Notes:   Both ends share the system clock but treat the pins as asynchronous
`timescale 1ns/1ps
interface pfp_if;
    logic       action_select_hi;
    logic       action_select_lo;
    logic       byte_select;
    logic [7:0] data;
    logic       load_strobe_pin;
    logic       write_n;
    logic       completion_indicator;

    modport dev (
        input  action_select_hi,
        input  action_select_lo,
        input  byte_select,
        input  data,
        input  load_strobe_pin,
        input  write_n,
        output completion_indicator
    );
    modport prog (
        output action_select_hi,
        output action_select_lo,
        output byte_select,
        output data,
        output load_strobe_pin,
        output write_n,
        input  completion_indicator
    );
endinterface

/* File: core/page_buffer.sv */
// Purpose: One page of program words, filled byte by byte
// Assumes: Low and high byte writes never occur in the same cycle
// Notes:   No reset on the array; content is data, not control
`timescale 1ns/1ps
module page_buffer
    import pfp_pkg::*;
(
    // Clock
    input  wire logic               clk_sys_i,
    // Fill side
    input  wire logic               wr_lo_i,
    input  wire logic               wr_hi_i,
    input  wire logic [PAGE_AW-1:0] wr_idx_i,
    input  wire logic [7:0]         wr_byte_i,
    // Drain side
    input  wire logic [PAGE_AW-1:0] rd_idx_i,
    output logic      [15:0]        rd_word_o
);
    logic [7:0] lo_mem [2**PAGE_AW];
    logic [7:0] hi_mem [2**PAGE_AW];

    // Byte lanes kept apart so each half is written alone
    always_ff @(posedge clk_sys_i) begin
        if (wr_lo_i) begin
            lo_mem[wr_idx_i] <= wr_byte_i;
        end
        if (wr_hi_i) begin
            hi_mem[wr_idx_i] <= wr_byte_i;
        end
    end

    // Asynchronous read so the copy moves one word per cycle
    assign rd_word_o = {hi_mem[rd_idx_i], lo_mem[rd_idx_i]};
endmodule

/* File: core/pfp_device.sv */
// Purpose: Device end of the parallel programming port
// Assumes: Pins are asynchronous to clk_sys_i; fuse input is a static level
// Notes:   Loads and write pulses arriving while busy are dropped
`timescale 1ns/1ps
module pfp_device
    import pfp_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    // Programming pins
    pfp_if.dev                       link,
    // Fuse, high means programmed
    input  wire logic                eeprom_preserve_fuse_i,
    // Backdoor EEPROM fill
    input  wire logic                ee_load_we_i,
    input  wire logic [EE_AW-1:0]    ee_load_addr_i,
    input  wire logic [7:0]          ee_load_data_i,
    // Memory inspection
    input  wire logic [FLASH_AW-1:0] flash_rd_addr_i,
    output logic      [15:0]         flash_rd_data_o,
    input  wire logic [EE_AW-1:0]    ee_rd_addr_i,
    output logic      [7:0]          ee_rd_data_o,
    output logic      [1:0]          lock_bits_o,
    output logic      [7:0]          command_o
);
    localparam int PIN_W = 13;

    logic [PIN_W-1:0]    pins_raw;
    logic [PIN_W-1:0]    pins_s1_q;
    logic [PIN_W-1:0]    pins_s2_q;
    logic [1:0]          edge_q;
    logic [7:0]          cmd_q;
    logic [7:0]          addr_lo_q;
    logic [7:0]          addr_hi_q;
    logic [1:0]          lock_q;
    logic [11:0]         cnt_q;
    logic [11:0]         cnt_d;
    logic                ready_q;
    dev_state_e          state_q;
    dev_state_e          state_d;
    logic [15:0]         flash_mem [2**FLASH_AW];
    logic [7:0]          ee_mem [2**EE_AW];
    logic [15:0]         flash_q;
    logic [7:0]          ee_q;
    logic [15:0]         buf_word;

    // Every pin passes two flops; latency traded for metastability safety
    assign pins_raw = {link.action_select_hi, link.action_select_lo, link.byte_select,
                       link.data, link.load_strobe_pin, link.write_n};

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pins_s1_q <= 13'h0001;
            pins_s2_q <= 13'h0001;
            edge_q    <= 2'h1;
        end else begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
            edge_q    <= pins_s2_q[1:0];
        end
    end

    // Pin decode, all from the second synchroniser stage
    wire       strobe_rise = pins_s2_q[1] & ~edge_q[1];
    wire       wr_fall     = ~pins_s2_q[0] & edge_q[0];
    wire [1:0] act         = pins_s2_q[12:11];
    wire       bsel        = pins_s2_q[10];
    wire [7:0] din         = pins_s2_q[9:2];
    wire       idle        = (state_q == ST_IDLE);
    wire       load_ok     = strobe_rise & idle;
    wire       cmd_load    = load_ok & (act == ACT_CMD);
    wire       addr_load   = load_ok & (act == ACT_ADDR);
    wire       data_load   = load_ok & (act == ACT_DATA);
    wire       buf_fill    = data_load & (cmd_q == CMD_WRITE_FLASH);
    wire       start_erase = wr_fall & idle & (cmd_q == CMD_CHIP_ERASE);
    wire       start_page  = wr_fall & idle & (cmd_q == CMD_WRITE_FLASH);

    // Latched command and address stay until reloaded
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_q     <= CMD_NOP;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
        end else begin
            if (cmd_load) begin
                cmd_q <= din;
            end
            if (addr_load && !bsel) begin
                addr_lo_q <= din;
            end
            if (addr_load && bsel) begin
                addr_hi_q <= din;
            end
        end
    end

    // Word within page from low bits, page from the rest
    wire [PAGE_AW-1:0]    word_idx  = addr_lo_q[PAGE_AW-1:0];
    wire [PAGE_NUM_W-1:0] page_num  = {addr_hi_q[3:0], addr_lo_q[7:PAGE_AW]};

    page_buffer u_page_buffer (
        .clk_sys_i (clk_sys_i),
        .wr_lo_i   (buf_fill & ~bsel),
        .wr_hi_i   (buf_fill & bsel),
        .wr_idx_i  (word_idx),
        .wr_byte_i (din),
        .rd_idx_i  (cnt_q[PAGE_AW-1:0]),
        .rd_word_o (buf_word)
    );

    // Sequencer: erase walks flash, then EEPROM unless the fuse is programmed, then locks
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 12'h001;
        case (state_q)
            ST_IDLE: begin
                cnt_d = 12'h000;
                if (start_erase) begin
                    state_d = ST_ERASE_FLASH;
                end else if (start_page) begin
                    state_d = ST_PAGE_COPY;
                end
            end
            ST_ERASE_FLASH: begin
                if (cnt_q == FLASH_LAST) begin
                    cnt_d   = 12'h000;
                    state_d = eeprom_preserve_fuse_i ? ST_ERASE_LOCK : ST_ERASE_EE;
                end
            end
            ST_ERASE_EE: begin
                if (cnt_q == EE_LAST) begin
                    cnt_d   = 12'h000;
                    state_d = ST_ERASE_LOCK;
                end
            end
            ST_ERASE_LOCK: begin
                cnt_d   = 12'h000;
                state_d = ST_SETTLE;
            end
            ST_PAGE_COPY: begin
                if (cnt_q == PAGE_LAST) begin
                    cnt_d   = 12'h000;
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (cnt_q == SETTLE_LAST) begin
                    cnt_d   = 12'h000;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                cnt_d   = 12'h000;
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 12'h000;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ready_q <= (state_d == ST_IDLE);
        end
    end

    // Lock bits touched only once the flash walk is over; fuses never
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lock_q <= LOCK_RESET;
        end else if (state_q == ST_ERASE_LOCK) begin
            lock_q <= LOCK_ERASED;
        end
    end

    // Flash port: erase fill or page copy
    wire                flash_we = (state_q == ST_ERASE_FLASH) | (state_q == ST_PAGE_COPY);
    wire                erasing  = (state_q == ST_ERASE_FLASH);
    wire [FLASH_AW-1:0] flash_wa = erasing ? cnt_q : {page_num, cnt_q[PAGE_AW-1:0]};
    wire [15:0]         flash_wd = erasing ? ERASED_WORD : buf_word;

    // EEPROM port: erase wins over the backdoor
    wire             ee_erasing = (state_q == ST_ERASE_EE);
    wire             ee_we      = ee_erasing | ee_load_we_i;
    wire [EE_AW-1:0] ee_wa      = ee_erasing ? cnt_q[EE_AW-1:0] : ee_load_addr_i;
    wire [7:0]       ee_wd      = ee_erasing ? ERASED_BYTE : ee_load_data_i;

    // Arrays carry no reset; unwritten words are unknown until erased
    always_ff @(posedge clk_sys_i) begin
        if (flash_we) begin
            flash_mem[flash_wa] <= flash_wd;
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
        flash_q <= flash_mem[flash_rd_addr_i];
        ee_q    <= ee_mem[ee_rd_addr_i];
    end

    // Outputs
    assign link.completion_indicator = ready_q;
    assign flash_rd_data_o           = flash_q;
    assign ee_rd_data_o              = ee_q;
    assign lock_bits_o               = lock_q;
    assign command_o                 = cmd_q;
endmodule

/* File: core/pfp_programmer.sv */
// Purpose: Programmer end; turns register orders into pin sequences
// Assumes: Software sequences the load order per word itself
// Notes:   Orders while busy or device not ready are dropped and flagged
`timescale 1ns/1ps
module pfp_programmer
    import pfp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Programming pins
    pfp_if.prog              link,
    // Register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o
);
    host_state_e state_q;
    host_state_e state_d;
    logic [3:0]  step_q;
    logic [3:0]  step_d;
    logic [1:0]  act_q;
    logic        bs_q;
    logic [7:0]  data_q;
    logic        rdy_s1_q;
    logic        rdy_s2_q;
    logic        refused_q;
    logic [15:0] rdata_q;

    // Order decode
    wire idle       = (state_q == H_IDLE);
    wire can_take   = idle & rdy_s2_q;
    wire load_req   = reg_wr_i & (reg_addr_i == REG_LOAD);
    wire write_req  = reg_wr_i & (reg_addr_i == REG_WRITE);
    wire take_load  = load_req & can_take;
    wire take_write = write_req & can_take;
    wire refuse     = (load_req | write_req) & ~can_take;
    wire stat_rd    = reg_rd_i & (reg_addr_i == REG_STATUS);
    wire step_end   = (step_q == STEP_LAST);

    // Setup, strobe and hold each last one step so lines settle first
    always_comb begin
        state_d = state_q;
        step_d  = step_q + 4'h1;
        case (state_q)
            H_IDLE: begin
                step_d = 4'h0;
                if (take_load) begin
                    state_d = H_SETUP;
                end else if (take_write) begin
                    state_d = H_WRLOW;
                end
            end
            H_SETUP: begin
                if (step_end) begin
                    step_d  = 4'h0;
                    state_d = H_STROBE;
                end
            end
            H_STROBE: begin
                if (step_end) begin
                    step_d  = 4'h0;
                    state_d = H_HOLD;
                end
            end
            H_HOLD: begin
                if (step_end) begin
                    step_d  = 4'h0;
                    state_d = H_IDLE;
                end
            end
            H_WRLOW: begin
                if (step_end) begin
                    step_d  = 4'h0;
                    state_d = H_GAP;
                end
            end
            H_GAP: begin
                // Device needs time to drop ready before it can be trusted
                if (step_q == GAP_LAST) begin
                    step_d  = 4'h0;
                    state_d = H_IDLE;
                end
            end
            default: begin
                step_d  = 4'h0;
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= H_IDLE;
            step_q  <= 4'h0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
        end
    end

    // Pin lines held from order to next order
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            act_q  <= ACT_CMD;
            bs_q   <= 1'b0;
            data_q <= CMD_NOP;
        end else if (take_load) begin
            act_q  <= reg_wdata_i[10:9];
            bs_q   <= reg_wdata_i[8];
            data_q <= reg_wdata_i[7:0];
        end
    end

    // Ready synchroniser, refusal flag and read data
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdy_s1_q  <= 1'b0;
            rdy_s2_q  <= 1'b0;
            refused_q <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            rdy_s1_q  <= link.completion_indicator;
            rdy_s2_q  <= rdy_s1_q;
            refused_q <= refuse | (refused_q & ~stat_rd);  // Set beats clear
            rdata_q   <= 16'h0000;
            if (stat_rd) begin
                rdata_q[STAT_READY]   <= rdy_s2_q;
                rdata_q[STAT_BUSY]    <= ~idle;
                rdata_q[STAT_REFUSED] <= refused_q;
            end
        end
    end

    // Pins from state flops and held lines
    assign link.action_select_hi = act_q[1];
    assign link.action_select_lo = act_q[0];
    assign link.byte_select      = bs_q;
    assign link.data             = data_q;
    assign link.load_strobe_pin  = (state_q == H_STROBE);
    assign link.write_n          = (state_q != H_WRLOW);
    assign reg_rdata_o           = rdata_q;
endmodule

/* File: verification/pfp_properties.sv */
// Purpose: Pin-level timing checks between programmer and device ends
// Assumes: Both ends run on clk_sys_i; only the pins are visible here
// Notes:   Busy lengths follow the fixed page and erase walks
`timescale 1ns/1ps
module pfp_properties
    import pfp_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // Programming pins
    input wire logic       action_select_hi,
    input wire logic       action_select_lo,
    input wire logic       byte_select,
    input wire logic [7:0] data,
    input wire logic       load_strobe_pin,
    input wire logic       write_n,
    input wire logic       completion_indicator
);
    logic [7:0]  cmd_q;
    logic [7:0]  op_q;
    logic [12:0] low_cnt_q;
    logic [7:0]  since_wr_q;
    wire  [10:0] lines = {action_select_hi, action_select_lo, byte_select, data};
    wire         act_op = (cmd_q == CMD_CHIP_ERASE) || (cmd_q == CMD_WRITE_FLASH);

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Track last command, the op that went busy, and busy length
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_q      <= CMD_NOP;
            op_q       <= CMD_NOP;
            low_cnt_q  <= 13'h0000;
            since_wr_q <= 8'hFF;
        end else begin
            if ($rose(load_strobe_pin) && {action_select_hi, action_select_lo} == ACT_CMD) begin
                cmd_q <= data;
            end
            if ($fell(write_n)) begin
                op_q <= cmd_q;
            end
            low_cnt_q  <= completion_indicator ? 13'h0000 : low_cnt_q + 13'h0001;
            since_wr_q <= !write_n ? 8'h00 : since_wr_q + {7'h00, since_wr_q != 8'hFF};
        end
    end

    a_strobe_width: assert property ($rose(load_strobe_pin) |-> load_strobe_pin[*4] ##1 !load_strobe_pin)
        else $error("load strobe pulse width wrong");
    a_lines_setup: assert property ($rose(load_strobe_pin) |-> lines == $past(lines, 3))
        else $error("select or data changed just before strobe");
    a_lines_hold: assert property ($fell(load_strobe_pin) |-> lines == $past(lines, 4))
        else $error("select or data changed during strobe");
    a_write_width: assert property ($fell(write_n) |-> !write_n[*4] ##1 write_n)
        else $error("write pulse width wrong");
    a_busy_start: assert property ($fell(write_n) && completion_indicator && act_op
        |-> ##[3:6] !completion_indicator)
        else $error("busy did not follow write pulse");
    a_nop_ignored: assert property ($fell(write_n) && cmd_q == CMD_NOP
        |-> completion_indicator[*8])
        else $error("write pulse after no-operation went busy");
    a_busy_length: assert property ($rose(completion_indicator) |->
        (op_q == CMD_WRITE_FLASH) ? (low_cnt_q inside {[41:43]})
        : (low_cnt_q inside {[4106:4108], [4618:4620]}))
        else $error("busy length wrong");
    a_busy_cause: assert property ($fell(completion_indicator) |-> since_wr_q < 8'h08)
        else $error("busy without a write pulse");
    a_load_when_ready: assert property (($rose(load_strobe_pin) || $fell(write_n))
        |-> completion_indicator)
        else $error("programmer acted while device busy");

    // Main scenarios
    c_erase: cover property ($rose(completion_indicator) && op_q == CMD_CHIP_ERASE);
    c_page: cover property ($rose(completion_indicator) && op_q == CMD_WRITE_FLASH);
    c_nop: cover property ($fell(write_n) && cmd_q == CMD_NOP);
endmodule

/* File: verification/parallel_flash_programming_port_tb_top.sv */
// Purpose: Both ends joined; register orders checked against a memory model
// Assumes: Software waits for idle and ready between orders
// Notes:   Arrays are erased before any read-back compare
`timescale 1ns/1ps
module parallel_flash_programming_port_tb_top;
    import pfp_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [1:0]  reg_addr_i = 2'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        fuse_i = 1'b0;
    logic        ee_we_i = 1'b0;
    logic [8:0]  ee_wa_i = 9'h000;
    logic [7:0]  ee_wd_i = 8'h00;
    logic [11:0] fl_ra_i = 12'h000;
    logic [8:0]  ee_ra_i = 9'h000;
    logic [15:0] fl_rd_o;
    logic [7:0]  ee_rd_o;
    logic [1:0]  lock_o;
    logic [7:0]  cmd_o;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [31:0] seed = 32'h0000D09C;
    logic [15:0] mdl_fl [4096];
    logic [7:0]  mdl_ee [512];
    logic [15:0] pbuf [32];
    logic [1:0]  mdl_lock = LOCK_RESET;
    logic [15:0] v;
    logic [6:0]  pg;

    always #5 clk_sys_i = ~clk_sys_i;

    pfp_if link();
    pfp_programmer pfp_programmer_i (.clk_sys_i, .rst_n_i, .link(link.prog), .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
    pfp_device pfp_device_i (.clk_sys_i, .rst_n_i, .link(link.dev),
        .eeprom_preserve_fuse_i(fuse_i), .ee_load_we_i(ee_we_i), .ee_load_addr_i(ee_wa_i),
        .ee_load_data_i(ee_wd_i), .flash_rd_addr_i(fl_ra_i), .flash_rd_data_o(fl_rd_o),
        .ee_rd_addr_i(ee_ra_i), .ee_rd_data_o(ee_rd_o), .lock_bits_o(lock_o),
        .command_o(cmd_o));
    pfp_properties pfp_properties_i (.clk_sys_i, .rst_n_i,
        .action_select_hi(link.action_select_hi), .action_select_lo(link.action_select_lo),
        .byte_select(link.byte_select), .data(link.data),
        .load_strobe_pin(link.load_strobe_pin), .write_n(link.write_n),
        .completion_indicator(link.completion_indicator));

    // Xorshift source for page data, page numbers and EEPROM fill
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bus tasks start and end just after a rising edge
    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rdata_o;
        @(posedge clk_sys_i);
    endtask

    // Polling bounds a hang; an erase needs about 2300 polls
    task automatic wait_idle();
        logic [15:0] s;
        for (int n = 0; n < 3000; n++) begin
            reg_rd(REG_STATUS, s);
            if (s[STAT_BUSY] === 1'b0 && s[STAT_READY] === 1'b1) return;
        end
        num_errors++;
        $display("wrong value status expected idle seen busy");
    endtask

    task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] d);
        reg_wr(REG_LOAD, {5'h00, act, bs, d});
        wait_idle();
    endtask

    task automatic rd_mem(input logic [11:0] a);
        fl_ra_i <= a;
        ee_ra_i <= a[8:0];
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("flash", fl_rd_o, mdl_fl[a]);
        if (a < 12'h200) check("eeprom", {8'h00, ee_rd_o}, {8'h00, mdl_ee[a[8:0]]});
        @(posedge clk_sys_i);
    endtask

    task automatic ee_fill();
        for (int i = 0; i < 8; i++) begin
            v = 16'(rnd());
            ee_wa_i <= v[8:0];
            ee_wd_i <= v[15:8];
            ee_we_i <= 1'b1;
            mdl_ee[v[8:0]] = v[15:8];
            @(posedge clk_sys_i);
        end
        ee_we_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // Lock bits must keep the old value while flash is still erasing
    task automatic do_erase();
        ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
        reg_wr(REG_WRITE, 16'h0000);
        // A load while the write pulse runs must be dropped and flagged
        @(posedge clk_sys_i);
        reg_wr(REG_LOAD, {5'h00, ACT_CMD, 1'b0, CMD_NOP});
        reg_rd(REG_STATUS, v);
        check("refused busy", v & 16'h0006, 16'h0006);
        repeat (100) @(posedge clk_sys_i);
        check("lock mid", {14'h0000, lock_o}, {14'h0000, mdl_lock});
        wait_idle();
        foreach (mdl_fl[a]) mdl_fl[a] = ERASED_WORD;
        if (!fuse_i) foreach (mdl_ee[a]) mdl_ee[a] = ERASED_BYTE;
        mdl_lock = LOCK_ERASED;
        check("lock", {14'h0000, lock_o}, {14'h0000, LOCK_ERASED});
        check("command", {8'h00, cmd_o}, {8'h00, CMD_CHIP_ERASE});
        for (int a = 0; a < 4096; a++) rd_mem(12'(a));
    endtask

    // First page loads command and high address; later ones reuse them
    task automatic prog_page(input logic [6:0] p, input logic first);
        if (first) ld(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
        for (int i = 0; i < 32; i++) begin
            pbuf[i] = 16'(rnd());
            ld(ACT_ADDR, 1'b0, {p[2:0], 5'(i)});
            ld(ACT_DATA, 1'b0, pbuf[i][7:0]);
            ld(ACT_DATA, 1'b1, pbuf[i][15:8]);
        end
        if (first) ld(ACT_ADDR, 1'b1, {4'h0, p[6:3]});
        reg_wr(REG_WRITE, 16'h0000);
        wait_idle();
        for (int i = 0; i < 32; i++) mdl_fl[{p, 5'(i)}] = pbuf[i];
        check("command", {8'h00, cmd_o}, {8'h00, CMD_WRITE_FLASH});
        for (int i = 0; i < 32; i++) rd_mem({p, 5'(i)});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check("ready", {15'h0000, link.completion_indicator}, 16'h0001);
        check("lock", {14'h0000, lock_o}, {14'h0000, LOCK_RESET});
        check("command", {8'h00, cmd_o}, {8'h00, CMD_NOP});
        $display("test reset done");
        ee_fill();
        do_erase();
        $display("test erase done");
        fuse_i <= 1'b1;
        ee_fill();
        pg = 7'(rnd());
        prog_page(pg, 1'b1);
        prog_page(pg ^ 7'h01, 1'b0);
        $display("test page done");
        ld(ACT_CMD, 1'b0, CMD_NOP);
        reg_wr(REG_WRITE, 16'h0000);
        wait_idle();
        check("command", {8'h00, cmd_o}, {8'h00, CMD_NOP});
        rd_mem({pg, 5'h00});
        $display("test nop done");
        do_erase();
        $display("test preserve done");
        reg_rd(2'h3, v);
        check("unmapped", v, 16'h0000);
        $display("test unmapped done");
        wrap_up();
    end

    // Watchdog sized well above the roughly 28000 cycles of the sequence
    initial begin
        repeat (80000) @(posedge clk_sys_i);
        num_errors++;
        wrap_up();
    end
endmodule
